// ---- common/adsw_pkg.sv ----
// shared constants and bit helpers for the serial converter word control
package adsw_pkg;

  // result and configuration word shapes
  localparam int RES_W = 10;
  localparam int CFG_W = 8;
  localparam int CNT_W = 5;

  // configuration byte field positions, first received bit is bit 7
  localparam int MUX_HI = 7;
  localparam int MUX_LO = 4;
  localparam int UNI_BIT = 3;
  localparam int BIT_ORDER_SELECT_BIT = 2;
  localparam int WL_HI_BIT = 1;
  localparam int WL_LO_BIT = 0;

  // configuration held before the first exchange: msb first, 8-bit word
  localparam logic [CFG_W-1:0] CFG_RST = 8'h04;

  // output word lengths
  localparam logic [CNT_W-1:0] LEN_8 = 5'h08;
  localparam logic [CNT_W-1:0] LEN_10 = 5'h0a;
  localparam logic [CNT_W-1:0] LEN_12 = 5'h0c;
  localparam logic [CNT_W-1:0] LEN_16 = 5'h10;
  localparam logic [CNT_W-1:0] CNT_MAX = 5'h1f;

  // chip select must be seen stable this many conversion-clock cycles
  localparam int STABLE_CYCLES = 2;

  // conversion time and clock rate; least time rounds up
  localparam int CONV_TIME_NS = 22000;
  localparam int CLK_MHZ = 200;
  localparam int CONV_CYCLES_DEF = (CONV_TIME_NS * CLK_MHZ + 999) / 1000;

  // output word length from the two length bits
  function automatic logic [CNT_W-1:0] word_len(input logic [1:0] wl);
    logic [CNT_W-1:0] len;
    len = LEN_8;
    case (wl)
      2'h0: len = LEN_8;
      2'h1: len = LEN_10;
      2'h2: len = LEN_12;
      2'h3: len = LEN_16;
    endcase
    return len;
  endfunction

  // value of output position pos of the formatted result
  function automatic logic out_bit(input logic [CNT_W-1:0] pos,
                                   input logic [RES_W-1:0] res,
                                   input logic bit_order_select,
                                   input logic uni,
                                   input logic [CNT_W-1:0] len);
    logic b;
    logic [3:0] idx;
    b = 1'b0;
    idx = 4'(RES_W - 1) - pos[3:0];
    if (pos >= len) begin
      b = 1'b0;
    end else if (pos < CNT_W'(RES_W)) begin
      b = bit_order_select ? res[idx] : res[pos[3:0]];
    end else if (!bit_order_select && !uni) begin
      b = res[RES_W-1];
    end
    return b;
  endfunction

endpackage

// ---- tb/adsw_ctrl_props.sv ----
// concurrent checks on the serial word control ports
`timescale 1ns/1ps
module adsw_ctrl_props #(
  parameter int CONV_CYCLES = 20
) (
  input wire logic sys_clk, // conversion clock
  input wire logic srst, // sync reset
  input wire logic sclk, // shift clock
  input wire logic cs_n_i, // select pin, active low
  input wire logic din_i, // config data
  input wire logic [adsw_pkg::RES_W-1:0] conv_code_i, // raw code
  input wire logic dout_o, // serial result
  input wire logic dout_oe_o, // driver enable
  input wire logic cs_seen_o, // select recognised
  input wire logic conv_start_o, // start pulse
  input wire logic conv_busy_o, // converting
  input wire logic conv_uni_o, // polarity
  input wire logic [3:0] conv_mux_o // mux bits
);
  logic [7:0] busy_len_r;

  // busy run length, cleared between runs so each run is judged alone
  always_ff @(posedge sys_clk) begin
    if (srst || !conv_busy_o) begin
      busy_len_r <= 8'h00;
    end else begin
      busy_len_r <= busy_len_r + 8'h01;
    end
  end

  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);

  // select pin held long enough to pass the filter
  sequence s_sel_low;
    (!cs_n_i) [*8];
  endsequence
  sequence s_sel_high;
    cs_n_i [*8];
  endsequence

  property p_seen_low;
    s_sel_low |-> cs_seen_o;
  endproperty
  property p_seen_high;
    s_sel_high |-> !cs_seen_o && !dout_oe_o;
  endproperty
  property p_rise_wait;
    $rose(cs_seen_o) |-> !$past(cs_n_i, 4) && !$past(cs_n_i, 5);
  endproperty
  property p_oe_on;
    $rose(cs_seen_o) && !conv_busy_o |=> dout_oe_o;
  endproperty
  property p_oe_sel;
    dout_oe_o |-> cs_seen_o;
  endproperty
  property p_busy_len;
    $fell(conv_busy_o) |-> busy_len_r == 8'(CONV_CYCLES);
  endproperty
  property p_start_pulse;
    conv_start_o |=> !conv_start_o && conv_busy_o;
  endproperty
  property p_quiet_busy;
    conv_busy_o && $past(conv_busy_o, 2) |-> !dout_oe_o;
  endproperty
  property p_cfg_hold;
    !conv_start_o && !$past(conv_start_o) |-> $stable(conv_mux_o) && $stable(conv_uni_o);
  endproperty
  property p_launch_fall;
    dout_oe_o && $past(dout_oe_o) && $changed(dout_o) |-> !$past(sclk);
  endproperty

  a_seen_low: assert property (p_seen_low) else $error("select low not seen");
  a_seen_high: assert property (p_seen_high) else $error("select high not seen");
  a_rise_wait: assert property (p_rise_wait) else $error("select seen too soon");
  a_oe_on: assert property (p_oe_on) else $error("driver not on");
  a_oe_sel: assert property (p_oe_sel) else $error("driver on unselected");
  a_busy_len: assert property (p_busy_len) else $error("busy length wrong");
  a_start_pulse: assert property (p_start_pulse) else $error("start not a pulse");
  a_quiet_busy: assert property (p_quiet_busy) else $error("driver on while busy");
  a_cfg_hold: assert property (p_cfg_hold) else $error("config moved");
  a_launch_fall: assert property (p_launch_fall) else $error("dout moved, sclk high");
endmodule

bind adsw_ctrl adsw_ctrl_props #(.CONV_CYCLES(CONV_CYCLES)) i_props (
  .sys_clk(sys_clk), .srst(srst), .sclk(sclk), .cs_n_i(cs_n_i), .din_i(din_i),
  .conv_code_i(conv_code_i), .dout_o(dout_o), .dout_oe_o(dout_oe_o),
  .cs_seen_o(cs_seen_o), .conv_start_o(conv_start_o), .conv_busy_o(conv_busy_o),
  .conv_uni_o(conv_uni_o), .conv_mux_o(conv_mux_o));

// ---- tb/adsw_host_model.sv ----
// host serial port model: select, shift clock and config data
`timescale 1ns/1ps
module adsw_host_model (
  input wire logic lclk, // link clock
  input wire logic dout, // line level of the result
  input wire logic dout_oe, // device driving the line
  output logic sclk, // shift clock, also toggled outside frames by junk
  output logic cs_n, // select, active low
  output logic din // config data
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    din = 1'b0;
  end

  // unselected data line keeps moving so stale bits cannot pass
  always @(posedge lclk) begin
    if (cs_n) begin
      din <= ~din;
    end
  end

  // one exchange; half periods of 36 ns leave dout time to settle
  task automatic xfer(input logic [7:0] cfg, input logic [7:0] pad, input int len,
                      input bit hold, output logic [15:0] got, output bit ok);
    int n;
    got = 16'h0000;
    n = 0;
    @(posedge lclk);
    cs_n <= 1'b0;
    while (dout_oe !== 1'b1 && n < 200) begin
      @(posedge lclk);
      n++;
    end
    ok = (n < 200);
    for (int k = 0; k < len; k++) begin
      din <= (k < 8) ? cfg[(7-k)&7] : pad[k&7];
      repeat (3) @(posedge lclk);
      got[k] = dout;
      sclk <= 1'b1;
      repeat (3) @(posedge lclk);
      sclk <= 1'b0;
    end
    repeat (3) @(posedge lclk);
    if (!hold) begin
      cs_n <= 1'b1;
    end
  endtask // sclk stays low while held select waits

  // select pulse shorter than one conversion clock
  task automatic glitch();
    @(posedge lclk);
    #1;
    cs_n = 1'b0;
    #3;
    cs_n = 1'b1;
  endtask

  // clocks with select high must be ignored
  task automatic junk(input int n);
    repeat (2 * n) begin
      @(posedge lclk);
      sclk <= ~sclk;
    end
  endtask
endmodule

// ---- tb/test_adc_serial_word_control.sv ----
// self-checking bench for the serial word control
`timescale 1ns/1ps
module test_adc_serial_word_control;
  logic sys_clk, lclk, srst, sclk, cs_n, din, dout_w;
  logic dout, dout_oe, cs_seen, conv_start, conv_busy, conv_uni;
  logic [9:0] code, pcode;
  logic [3:0] conv_mux;
  logic [7:0] cfg;
  logic [15:0] got;
  logic pm, pu;
  bit ok;
  logic [9:0] corner [4] = '{10'h000, 10'h3ff, 10'h200, 10'h1ff};
  int n_errors = 0;
  int n_compared = 0;

  // two unrelated clocks
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  initial begin
    lclk = 1'b0;
    #1.3;
    forever #6 lclk = ~lclk;
  end
  assign dout_w = dout_oe ? dout : lclk; // released line shows a moving pattern

  adsw_ctrl #(.CONV_CYCLES(20)) i_dut (.sys_clk(sys_clk), .srst(srst), .sclk(sclk),
    .cs_n_i(cs_n), .din_i(din), .conv_code_i(code), .dout_o(dout), .dout_oe_o(dout_oe),
    .cs_seen_o(cs_seen), .conv_start_o(conv_start), .conv_busy_o(conv_busy),
    .conv_uni_o(conv_uni), .conv_mux_o(conv_mux));
  adsw_host_model i_host (.lclk(lclk), .dout(dout_w), .dout_oe(dout_oe), .sclk(sclk),
    .cs_n(cs_n), .din(din));

  function automatic int len_of(input logic [1:0] wl);
    return (wl == 2'h0) ? 8 : (wl == 2'h1) ? 10 : (wl == 2'h2) ? 12 : 16;
  endfunction

  // expected word, bit k is the k-th bit on the line
  function automatic logic [15:0] exp_word(input logic [9:0] c, input logic m,
                                           input logic u, input logic [1:0] wl);
    logic [9:0] r;
    logic [15:0] w;
    r = u ? c : {~c[9], c[8:0]};
    w = 16'h0000;
    for (int k = 0; k < len_of(wl); k++) begin
      if (k < 10) begin
        w[k] = m ? r[9-k] : r[k];
      end else begin
        w[k] = (!m && !u) ? r[9] : 1'b0;
      end
    end
    return w;
  endfunction

  task automatic chk_w(input logic [15:0] g, input logic [15:0] e);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %0t word %h expected %h", $time, g, e);
    end
  endtask
  task automatic chk_b(input logic g, input logic e);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %0t flag %b expected %b", $time, g, e);
    end
  endtask

  task automatic tally_and_finish();
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // bounded wait on the busy flag
  task automatic wait_busy(input logic lvl);
    int n;
    n = 0;
    while (conv_busy !== lvl && n < 1000) begin
      @(negedge sys_clk);
      n++;
    end
    if (n >= 1000) begin
      n_errors++;
      $display("CHECK FAILED %0t wait ran out", $time);
      tally_and_finish();
    end
  endtask

  // glitch, then a sweep of every polarity, order and length, then random
  initial begin
    srst = 1'b1;
    code = 10'h000;
    void'($urandom(69));
    repeat (20) @(negedge sys_clk);
    srst = 1'b0;
    pcode = 10'h000;
    pm = 1'b1;
    pu = 1'b1;
    i_host.glitch();
    repeat (12) begin
      @(negedge sys_clk);
      chk_b(cs_seen | dout_oe, 1'b0);
    end
    for (int i = 0; i < 26; i++) begin
      cfg = (i < 16) ? {4'($urandom), 4'(i)} : 8'($urandom);
      @(negedge sys_clk);
      code = (i < 4) ? corner[i] : 10'($urandom);
      if (cs_n === 1'b1) begin
        i_host.junk(3);
      end
      i_host.xfer(cfg, 8'($urandom), len_of(cfg[1:0]), (i % 5 == 3), got, ok);
      chk_b(ok, 1'b1);
      if (!ok) begin
        tally_and_finish();
      end
      chk_w(got, exp_word(pcode, pm, pu, cfg[1:0]));
      wait_busy(1'b1);
      chk_b(conv_uni, cfg[3]);
      chk_w({12'h000, conv_mux}, {12'h000, cfg[7:4]});
      wait_busy(1'b0);
      pcode = code;
      pm = cfg[2];
      pu = cfg[3];
    end
    tally_and_finish();
  end
endmodule

// ---- verilog/adsw_ctrl.sv ----
// serial word control: config capture, result formatting and output shifting
`timescale 1ns/1ps

// How it works
// - config bit three set means unipolar, clear means bipolar conversion.
// - unipolar result is straight binary, zero input gives all zeros.
// - bipolar result is two's complement formed from the offset code.
// - config bit two set sends msb first, clear sends lsb first.
// - bit order from one config byte orders the next transfer's word.
// - config byte always arrives first bit to msb, whatever the order.
// - last two config bits pick 8, 10, 12 or 16 output bits.
// - length bits govern the word shifted out in the same transfer.
// - chip select changes shorter than one conversion clock are ignored.
// - chip select level accepted after two conversion clocks, both directions.
// - recognised low chip select turns the serial output driver on while no conversion runs.
// - shift clock activity is ignored while chip select is high.
// - with select low, output drives first bit once conversion finishes.
// - msb first with 12 bits pads the last two positions with zeros.
// - data launches on falling and is captured on rising shift clock.
// - config bits taken on first eight rising edges, later bits ignored.
// - conversion starts at exchange end, result goes out next transfer.
// - lsb first long words pad zeros unipolar or sign copies bipolar.
module adsw_ctrl #(
  parameter int CONV_CYCLES = adsw_pkg::CONV_CYCLES_DEF
) (
  input wire logic sys_clk, // conversion clock, 200 MHz
  input wire logic srst, // synchronous reset, active high
  input wire logic sclk, // shift clock from the host
  input wire logic cs_n_i, // chip select pin, active low
  input wire logic din_i, // serial config data in
  input wire logic [adsw_pkg::RES_W-1:0] conv_code_i, // raw offset-binary code
  output logic dout_o, // serial result out
  output logic dout_oe_o, // output driver enable
  output logic cs_seen_o, // chip select low recognised
  output logic conv_start_o, // one-cycle conversion start
  output logic conv_busy_o, // conversion in progress
  output logic conv_uni_o, // polarity of current conversion
  output logic [3:0] conv_mux_o // multiplexer address bits
);

  localparam int CONV_W = $clog2(CONV_CYCLES + 1);
  localparam logic [CONV_W-1:0] CONV_LAST = CONV_W'(CONV_CYCLES - 1);

  // conversion-clock domain state
  logic cs_low;
  logic link_rst_r;
  logic link_por_r;
  logic conv_busy_r;
  logic [CONV_W-1:0] conv_cnt_r;
  logic conv_start_r;
  logic conv_uni_r;
  logic [3:0] conv_mux_r;
  logic pend_bit_order_select_r;
  logic [adsw_pkg::RES_W-1:0] result_r;
  logic cur_bit_order_select_r;
  logic cur_uni_r;
  logic req_d_r;
  logic req_s;
  logic req_evt;
  logic [1:0] tx_s;
  logic dout_r;
  logic dout_oe_r;
  logic cs_seen_r;

  // shift-clock domain state
  logic [adsw_pkg::CNT_W-1:0] rx_cnt_r;
  logic [adsw_pkg::CFG_W-1:0] cfg_sh_r;
  logic [adsw_pkg::CFG_W-1:0] cfg_hold_r;
  logic [adsw_pkg::CFG_W-1:0] cfg_now;
  logic req_tgl_r;
  logic [adsw_pkg::CNT_W-1:0] len_now;
  logic end_hit;
  logic [adsw_pkg::CNT_W-1:0] tx_pos_r;
  logic [adsw_pkg::CNT_W-1:0] tx_len;
  logic [adsw_pkg::CNT_W-1:0] tx_next;
  logic tx_bit_r;
  logic tx_run_r;

  // chip select filter
  adsw_deglitch #(
    .STABLE(adsw_pkg::STABLE_CYCLES)
  ) u_deglitch (
    .sys_clk(sys_clk),
    .srst(srst),
    .cs_n_pin(cs_n_i),
    .cs_low_r(cs_low)
  );

  // exchange-end toggle into the conversion clock
  adsw_sync #(
    .W(1)
  ) u_req_sync (
    .clk(sys_clk),
    .srst(srst),
    .d(req_tgl_r),
    .q(req_s)
  );

  // launched output bit and run flag into the conversion clock
  adsw_sync #(
    .W(2)
  ) u_tx_sync (
    .clk(sys_clk),
    .srst(srst),
    .d({tx_run_r, tx_bit_r}),
    .q(tx_s)
  );

  // ------------------------------------------------------------------
  // link resets: the shift-clock logic has no free-running clock, so
  // its reset is a quasi-static level built here and applied async

  // link logic held in reset unless a low select is recognised and no
  // conversion runs; stray shift clocks then do nothing
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      link_rst_r <= 1'b1;
    end else begin
      link_rst_r <= ~cs_low | conv_busy_r;
    end
  end

  // power-on reset for the link state that must outlive a transfer
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      link_por_r <= 1'b1;
    end else begin
      link_por_r <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // receive side, rising shift clock

  // length of the present word; the last length bit may be on din now
  always_comb begin
    cfg_now = cfg_sh_r;
    if (rx_cnt_r == adsw_pkg::CNT_W'(adsw_pkg::CFG_W - 1)) begin
      cfg_now[adsw_pkg::WL_LO_BIT] = din_i;
    end
    len_now = adsw_pkg::word_len(cfg_now[adsw_pkg::WL_HI_BIT:adsw_pkg::WL_LO_BIT]);
    end_hit = (rx_cnt_r == len_now - 5'h01);
  end

  // rising-edge counter, saturates so long bursts cannot wrap
  always_ff @(posedge sclk or posedge link_rst_r) begin
    if (link_rst_r) begin
      rx_cnt_r <= '0;
    end else if (rx_cnt_r != adsw_pkg::CNT_MAX) begin
      rx_cnt_r <= rx_cnt_r + 5'h01;
    end
  end

  // first eight rising edges fill the byte, first bit into bit 7
  always_ff @(posedge sclk or posedge link_rst_r) begin
    if (link_rst_r) begin
      cfg_sh_r <= adsw_pkg::CFG_RST;
    end else if (rx_cnt_r < adsw_pkg::CNT_W'(adsw_pkg::CFG_W)) begin
      cfg_sh_r[3'(adsw_pkg::CFG_W - 1) - rx_cnt_r[2:0]] <= din_i;
    end
  end

  // at the exchange end flag a conversion; one toggle per exchange,
  // so a single synchronised bit carries the request
  always_ff @(posedge sclk or posedge link_por_r) begin
    if (link_por_r) begin
      req_tgl_r <= 1'b0;
    end else if (end_hit) begin
      req_tgl_r <= ~req_tgl_r;
    end
  end

  // the hold copy stays put until the next exchange end, so the
  // conversion clock may read it once the toggle has crossed
  always_ff @(posedge sclk or posedge link_por_r) begin
    if (link_por_r) begin
      cfg_hold_r <= adsw_pkg::CFG_RST;
    end else if (end_hit) begin
      cfg_hold_r <= cfg_now;
    end
  end

  // ------------------------------------------------------------------
  // transmit side, falling shift clock

  // before the byte is complete the length is unknown, but positions
  // below eight are inside every legal length anyway
  always_comb begin
    if (rx_cnt_r >= adsw_pkg::CNT_W'(adsw_pkg::CFG_W)) begin
      tx_len = adsw_pkg::word_len(cfg_sh_r[adsw_pkg::WL_HI_BIT:adsw_pkg::WL_LO_BIT]);
    end else begin
      tx_len = adsw_pkg::LEN_16;
    end
    tx_next = tx_pos_r + 5'h01;
  end

  // marks that a falling edge has come, so dout follows the launched bit
  always_ff @(negedge sclk or posedge link_rst_r) begin
    if (link_rst_r) begin
      tx_run_r <= 1'b0;
    end else begin
      tx_run_r <= 1'b1;
    end
  end

  // each falling edge launches the next position of the word
  always_ff @(negedge sclk or posedge link_rst_r) begin
    if (link_rst_r) begin
      tx_pos_r <= '0;
      tx_bit_r <= 1'b0;
    end else begin
      if (tx_pos_r != adsw_pkg::CNT_MAX) begin
        tx_pos_r <= tx_next;
      end
      tx_bit_r <= adsw_pkg::out_bit(tx_next, result_r, cur_bit_order_select_r, cur_uni_r,
                                    tx_len);
    end
  end

  // ------------------------------------------------------------------
  // conversion sequencing on the conversion clock

  assign req_evt = req_s ^ req_d_r;

  // previous toggle level for edge detection
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      req_d_r <= 1'b0;
    end else begin
      req_d_r <= req_s;
    end
  end

  // conversion timer; a request while busy is a host error and dropped
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      conv_busy_r <= 1'b0;
      conv_cnt_r <= '0;
    end else if (!conv_busy_r && req_evt) begin
      conv_busy_r <= 1'b1;
      conv_cnt_r <= CONV_LAST;
    end else if (conv_busy_r) begin
      if (conv_cnt_r == '0) begin
        conv_busy_r <= 1'b0;
      end else begin
        conv_cnt_r <= conv_cnt_r - CONV_W'(1);
      end
    end
  end

  // one-cycle start pulse for the analogue core
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      conv_start_r <= 1'b0;
    end else begin
      conv_start_r <= !conv_busy_r && req_evt;
    end
  end

  // settings handed to the analogue core; taken only at a start, so a
  // dropped request cannot disturb a conversion in progress
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      conv_uni_r <= 1'b1;
      conv_mux_r <= 4'h0;
      pend_bit_order_select_r <= 1'b1;
    end else begin
      if (!conv_busy_r && req_evt) begin
        conv_uni_r <= cfg_hold_r[adsw_pkg::UNI_BIT];
        conv_mux_r <= cfg_hold_r[adsw_pkg::MUX_HI:adsw_pkg::MUX_LO];
        pend_bit_order_select_r <= cfg_hold_r[adsw_pkg::BIT_ORDER_SELECT_BIT];
      end
    end
  end

  // the finished code is formatted once here, so the word is stable
  // for the whole of the next transfer
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      result_r <= '0;
      cur_bit_order_select_r <= 1'b1;
      cur_uni_r <= 1'b1;
    end else if (conv_busy_r && conv_cnt_r == '0) begin
      if (conv_uni_r) begin
        result_r <= conv_code_i;
      end else begin
        result_r <= {~conv_code_i[adsw_pkg::RES_W-1],
                     conv_code_i[adsw_pkg::RES_W-2:0]};
      end
      cur_bit_order_select_r <= pend_bit_order_select_r;
      cur_uni_r <= conv_uni_r;
    end
  end

  // ------------------------------------------------------------------
  // output pins

  // driver on after low select is recognised and no conversion runs,
  // off again once high select is recognised
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      dout_oe_r <= 1'b0;
    end else begin
      dout_oe_r <= cs_low && !conv_busy_r;
    end
  end

  // recognised select level as seen by the outside, same edge as the driver
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      cs_seen_r <= 1'b0;
    end else begin
      cs_seen_r <= cs_low;
    end
  end

  // first position comes from the held word until the first falling
  // edge; after that the launched bit, three conversion clocks late,
  // which limits the shift clock rate
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      dout_r <= 1'b0;
    end else if (tx_s[1] && !link_rst_r) begin
      dout_r <= tx_s[0];
    end else begin
      dout_r <= adsw_pkg::out_bit('0, result_r, cur_bit_order_select_r, cur_uni_r,
                                  adsw_pkg::LEN_16);
    end
  end

  assign dout_o = dout_r;
  assign dout_oe_o = dout_oe_r;
  assign cs_seen_o = cs_seen_r;
  assign conv_start_o = conv_start_r;
  assign conv_busy_o = conv_busy_r;
  assign conv_uni_o = conv_uni_r;
  assign conv_mux_o = conv_mux_r;

endmodule

// ---- verilog/adsw_deglitch.sv ----
// chip select synchroniser and deglitch filter on the conversion clock
`timescale 1ns/1ps
module adsw_deglitch #(
  parameter int STABLE = adsw_pkg::STABLE_CYCLES
) (
  input wire logic sys_clk, // conversion clock
  input wire logic srst, // synchronous reset, active high
  input wire logic cs_n_pin, // raw chip select pin, active low
  output logic cs_low_r // recognised chip select low
);

  logic meta_r;
  logic samp_n_r;
  logic [3:0] stable_r;

  // two flops before the filter looks at the pin
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      meta_r <= 1'b1;
      samp_n_r <= 1'b1;
    end else begin
      meta_r <= cs_n_pin;
      samp_n_r <= meta_r;
    end
  end

  // a new level must hold for STABLE cycles; shorter pulses are dropped
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      stable_r <= 4'h0;
      cs_low_r <= 1'b0;
    end else if (samp_n_r == cs_low_r) begin
      if (stable_r == 4'(STABLE - 1)) begin
        cs_low_r <= ~samp_n_r;
        stable_r <= 4'h0;
      end else begin
        stable_r <= stable_r + 4'h1;
      end
    end else begin
      stable_r <= 4'h0;
    end
  end

endmodule

// ---- verilog/adsw_sync.sv ----
// two-flop synchroniser for levels entering the conversion-clock domain
`timescale 1ns/1ps
module adsw_sync #(
  parameter int W = 1
) (
  input wire logic clk, // destination clock
  input wire logic srst, // synchronous reset, active high
  input wire logic [W-1:0] d, // level from another domain
  output logic [W-1:0] q // synchronised level
);

  logic [W-1:0] meta_r;

  // first stage feeds only the second stage
  always_ff @(posedge clk) begin
    if (srst) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end

endmodule
